/* core/hpm_port_power.sv */
// Decided for this implementation: the strobed register port and the address map.
`timescale 1ns/1ps
module hpm_port_power
  import hpm_pkg::*;
#(
  parameter int HALF_PERIOD_CYC = BLINK_HALF_CYC
) (
  // Clock and reset
  input  wire logic                 clk,
  input  wire logic                 rst_b,
  // Register port
  input  wire logic [ADDR_W-1:0]    addr,
  input  wire logic [DATA_W-1:0]    wdata,
  input  wire logic                 wrStb,
  input  wire logic                 rdStb,
  output logic      [DATA_W-1:0]    rdata,
  // Interrupt
  output logic                      irq,
  // Port pins
  input  wire logic [NUM_PORTS-1:0] portOvercurrentSense_n,
  output logic      [NUM_PORTS-1:0] portPowerEnable,
  output logic      [NUM_PORTS-1:0] portStatusIndicator_n
);

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  hpm_state_t           st_ff;
  hpm_state_t           nxt_st;
  logic [NUM_PORTS-1:0] senseSync_n;
  logic [NUM_PORTS-1:0] ocLive;
  logic [NUM_PORTS-1:0] ocRise;
  logic                 wrCmd;
  logic                 wrCtrl;
  logic                 deconfig;
  logic [NUM_PORTS-1:0] setMask;
  logic [NUM_PORTS-1:0] clrMask;
  logic [NUM_PORTS-1:0] enMask;
  logic [NUM_PORTS-1:0] disMask;
  logic [NUM_PORTS-1:0] blinkKill;
  logic                 cntLast;
  logic [CNT_W-1:0]     cntLastVal;

  // ----------------------------------------------------------------
  // Overcurrent sensing
  // ----------------------------------------------------------------
  hpm_sync #(
    .WIDTH     (NUM_PORTS),
    .RESET_VAL ({NUM_PORTS{1'b1}})
  ) u_sense_sync (
    .clk   (clk),
    .rst_b (rst_b),
    .din   (portOvercurrentSense_n),
    .dout  (senseSync_n)
  );

  // Each port is judged only by its own sense line.
  assign ocLive = ~senseSync_n;
  assign ocRise = ocLive & ~st_ff.ocPrev;

  // ----------------------------------------------------------------
  // Request decode
  // ----------------------------------------------------------------
  assign wrCmd      = wrStb && (addr == REG_CMD);
  assign wrCtrl     = wrStb && (addr == REG_CTRL);
  assign deconfig   = wrCtrl && !wdata[CSR_CFG_BIT];
  assign setMask    = wrCmd ? wdata[CMD_SET_LSB +: NUM_PORTS] : '0;
  assign clrMask    = wrCmd ? wdata[CMD_CLR_LSB +: NUM_PORTS] : '0;
  assign enMask     = wrCmd ? wdata[CMD_EN_LSB +: NUM_PORTS] : '0;
  assign disMask    = wrCmd ? wdata[CMD_DIS_LSB +: NUM_PORTS] : '0;
  assign blinkKill  = clrMask | {NUM_PORTS{deconfig}};
  assign cntLastVal = CNT_W'(HALF_PERIOD_CYC - 1);
  assign cntLast    = (st_ff.blinkCnt == cntLastVal);

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    nxt_st        = st_ff;
    nxt_st.ocPrev = ocLive;

    // Controller status and mode writes; the mode bit steers nothing in the switching path.
    if (wrCtrl) begin
      nxt_st.cfgStat = wdata[CSR_W-1:0];
    end
    if (wrStb && (addr == REG_MODE)) begin
      nxt_st.selfPowered = wdata[0];
    end

    // Power is granted only on request and only once configured.
    nxt_st.power = st_ff.power | (setMask & {NUM_PORTS{st_ff.cfgStat[CSR_CFG_BIT]}});
    nxt_st.power = nxt_st.power & ~clrMask;
    nxt_st.blink = st_ff.blink & ~clrMask;

    // Dropping the configuration re-enumerates the hub: all ports go dark, except ports with live overcurrent, which blink.
    if (deconfig) begin
      nxt_st.power = '0;
      nxt_st.blink = '0;
    end

    // Overcurrent wins over any power request in the same cycle.
    nxt_st.power = nxt_st.power & ~ocLive;
    nxt_st.blink = nxt_st.blink | ocLive;

    // A port is enabled only while powered.
    nxt_st.enabled = (st_ff.enabled | enMask) & ~disMask & nxt_st.power;

    // Change and interrupt bits: set wins over a write-one clear.
    if (wrStb && (addr == REG_CHG)) begin
      nxt_st.ocChange = st_ff.ocChange & ~wdata[NUM_PORTS-1:0];
    end
    nxt_st.ocChange = nxt_st.ocChange | ocRise;
    if (wrStb && (addr == REG_IRQ_STAT)) begin
      nxt_st.irqStat = st_ff.irqStat & ~wdata[NUM_PORTS-1:0];
    end
    nxt_st.irqStat = nxt_st.irqStat | ocRise;
    if (wrStb && (addr == REG_IRQ_MASK)) begin
      nxt_st.irqMask = wdata[NUM_PORTS-1:0];
    end
    nxt_st.irq = |(nxt_st.irqStat & nxt_st.irqMask);

    // Free-running half-period counter.
    if (cntLast) begin
      nxt_st.blinkCnt   = '0;
      nxt_st.blinkPhase = ~st_ff.blinkPhase;
    end else begin
      nxt_st.blinkCnt = st_ff.blinkCnt + CNT_W'(1);
    end

    // Indicator: blink phase while the blink bit latched by overcurrent is set, else active low while enabled.
    nxt_st.ledN = (nxt_st.blink & {NUM_PORTS{nxt_st.blinkPhase}})
                | (~nxt_st.blink & ~nxt_st.enabled);

    // Read data stand for exactly one cycle after the read strobe.
    nxt_st.rdata = '0;
    if (rdStb) begin
      case (addr)
        REG_CTRL: begin
          nxt_st.rdata[CSR_W-1:0] = st_ff.cfgStat;
        end
        REG_PSTAT: begin
          nxt_st.rdata[PST_PWR_LSB +: NUM_PORTS]   = st_ff.power;
          nxt_st.rdata[PST_OC_LSB +: NUM_PORTS]    = ocLive;
          nxt_st.rdata[PST_EN_LSB +: NUM_PORTS]    = st_ff.enabled;
          nxt_st.rdata[PST_BLINK_LSB +: NUM_PORTS] = st_ff.blink;
        end
        REG_CHG: begin
          nxt_st.rdata[NUM_PORTS-1:0] = st_ff.ocChange;
        end
        REG_IRQ_STAT: begin
          nxt_st.rdata[NUM_PORTS-1:0] = st_ff.irqStat;
        end
        REG_IRQ_MASK: begin
          nxt_st.rdata[NUM_PORTS-1:0] = st_ff.irqMask;
        end
        REG_MODE: begin
          nxt_st.rdata[0] = st_ff.selfPowered;
        end
        default: begin
          nxt_st.rdata = '0;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      st_ff <= ST_RESET;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign rdata                 = st_ff.rdata;
  assign irq                   = st_ff.irq;
  assign portPowerEnable       = st_ff.power;
  assign portStatusIndicator_n = st_ff.ledN;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_b);

  logic [NUM_PORTS-1:0] setGrant;
  logic [NUM_PORTS-1:0] setWin;
  assign setGrant = setMask & {NUM_PORTS{st_ff.cfgStat[CSR_CFG_BIT]}};
  // A granted set that no overcurrent or clear in the same cycle overrides.
  assign setWin   = setGrant & ~ocLive & ~clrMask;

  AST_OC_POWER_OFF: assert property (
    (ocLive != '0) |=> ((portPowerEnable & $past(ocLive)) == '0))
    else $error("Power stayed on at an overcurrent port.");

  AST_OC_CHANGE_SET: assert property (
    (ocRise != '0) |=> (((st_ff.ocChange & $past(ocRise)) == $past(ocRise))
                        && ((st_ff.irqStat & $past(ocRise)) == $past(ocRise))))
    else $error("Overcurrent change bit not set on detection.");

  AST_NO_POWER_UNCFG: assert property (
    !st_ff.cfgStat[CSR_CFG_BIT] |-> (portPowerEnable == '0))
    else $error("Port powered while hub unconfigured.");

  AST_POWER_NEEDS_SET: assert property (
    ((portPowerEnable & ~$past(portPowerEnable)) != '0)
      |-> ((portPowerEnable & ~$past(portPowerEnable) & ~$past(setGrant)) == '0))
    else $error("Port power rose without a granted set request.");

  AST_CLR_POWER: assert property (
    (clrMask != '0) |=> ((portPowerEnable & $past(clrMask)) == '0))
    else $error("Clear request left port power on.");

  AST_BLINK_TOGGLE: assert property (
    cntLast |=> ((st_ff.blinkPhase != $past(st_ff.blinkPhase)) && (st_ff.blinkCnt == '0)))
    else $error("Blink phase did not toggle at the half period.");

  AST_LED_FOLLOWS_ENABLE: assert property (
    ((portStatusIndicator_n ^ ~st_ff.enabled) & ~st_ff.blink) == '0)
    else $error("Indicator does not follow port enable.");

  AST_LED_BLINK_PHASE: assert property (
    ((portStatusIndicator_n ^ {NUM_PORTS{st_ff.blinkPhase}}) & st_ff.blink) == '0)
    else $error("Blinking indicator not on blink phase.");

  AST_BLINK_HOLDS: assert property (
    (st_ff.blink != '0) |=> (($past(st_ff.blink) & ~$past(blinkKill) & ~st_ff.blink) == '0))
    else $error("Blink stopped without power-off or re-enumeration.");

  AST_RDATA_IDLE: assert property (
    !$past(rdStb) |-> (rdata == '0))
    else $error("Read data present without a read.");

  AST_OC_BLINKS: assert property (
    (ocLive != '0) |=> ((st_ff.blink & $past(ocLive)) == $past(ocLive)))
    else $error("Overcurrent port did not start blinking.");

  AST_PHASE_STABLE: assert property (
    !cntLast |=> (st_ff.blinkPhase == $past(st_ff.blinkPhase)))
    else $error("Blink phase changed before the half period ended.");

  AST_CNT_RANGE: assert property (
    st_ff.blinkCnt <= cntLastVal)
    else $error("Blink counter ran past its last value.");

  AST_ENABLE_NEEDS_POWER: assert property (
    (st_ff.enabled & ~portPowerEnable) == '0)
    else $error("Port enabled without power.");

  AST_LED_DARK_UNPOWERED: assert property (
    (~portStatusIndicator_n & ~portPowerEnable & ~st_ff.blink) == '0)
    else $error("Indicator lit on an unpowered port.");

  AST_DECONFIG_DARK: assert property (
    deconfig |=> ((portPowerEnable == '0) && (st_ff.enabled == '0)
                  && ((st_ff.blink & ~$past(ocLive)) == '0)))
    else $error("Deconfiguration left a port powered, enabled or blinking.");

  AST_SET_GRANTED: assert property (
    (setWin != '0) |=> ((portPowerEnable & $past(setWin)) == $past(setWin)))
    else $error("Granted set request did not power the port.");

  AST_CFG_WRITE: assert property (
    wrCtrl |=> (st_ff.cfgStat == CSR_W'($past(wdata))))
    else $error("Controller status write did not land.");

  AST_CHG_W1C: assert property (
    (wrStb && (addr == REG_CHG)) |=> ((st_ff.ocChange & NUM_PORTS'($past(wdata)) & ~$past(ocRise)) == '0))
    else $error("Change bit survived a write-one clear.");

  AST_PSTAT_OC: assert property (
    (rdStb && (addr == REG_PSTAT)) |=> (rdata[PST_OC_LSB +: NUM_PORTS] == $past(ocLive)))
    else $error("Status read did not show the live overcurrent level.");

  AST_IRQ_LEVEL: assert property (
    irq == |(st_ff.irqStat & st_ff.irqMask))
    else $error("Interrupt does not match unmasked status bits.");

  AST_MASK_WRITE: assert property (
    (wrStb && (addr == REG_IRQ_MASK)) |=> (st_ff.irqMask == NUM_PORTS'($past(wdata))))
    else $error("Interrupt mask write did not land.");

  COV_OC_EVENT: cover property (ocRise != '0);
  COV_POWER_ON: cover property ((setGrant != '0) ##1 (portPowerEnable != '0));
  COV_BLINK_TOGGLE: cover property ((st_ff.blink != '0) && cntLast);
  COV_IRQ: cover property ($rose(irq));
  COV_DECONFIG: cover property (deconfig && (portPowerEnable != '0));

endmodule : hpm_port_power

/* core/hpm_pkg.sv */
package hpm_pkg;

  // ----------------------------------------------------------------
  // Geometry and register bus
  // ----------------------------------------------------------------
  localparam int NUM_PORTS = 4;
  localparam int ADDR_W    = 8;
  localparam int DATA_W    = 32;

  localparam logic [ADDR_W-1:0] REG_CTRL     = 8'h00;
  localparam logic [ADDR_W-1:0] REG_CMD      = 8'h04;
  localparam logic [ADDR_W-1:0] REG_PSTAT    = 8'h08;
  localparam logic [ADDR_W-1:0] REG_CHG      = 8'h0c;
  localparam logic [ADDR_W-1:0] REG_IRQ_STAT = 8'h10;
  localparam logic [ADDR_W-1:0] REG_IRQ_MASK = 8'h14;
  localparam logic [ADDR_W-1:0] REG_MODE     = 8'h18;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int CMD_SET_LSB   = 0;
  localparam int CMD_CLR_LSB   = 4;
  localparam int CMD_EN_LSB    = 8;
  localparam int CMD_DIS_LSB   = 12;
  localparam int PST_PWR_LSB   = 0;
  localparam int PST_OC_LSB    = 4;
  localparam int PST_EN_LSB    = 8;
  localparam int PST_BLINK_LSB = 12;
  localparam int CSR_CFG_BIT   = 0;
  localparam int CSR_W         = 4;
  localparam logic [CSR_W-1:0] CSR_RESET = 4'h0;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_KHZ        = 25000;
  localparam int BLINK_HALF_MS  = 500;
  localparam int BLINK_HALF_CYC = BLINK_HALF_MS * CLK_KHZ;
  localparam int CNT_W          = 24;

  // ----------------------------------------------------------------
  // State of the power manager
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [CSR_W-1:0]     cfgStat;
    logic                 selfPowered;
    logic [NUM_PORTS-1:0] power;
    logic [NUM_PORTS-1:0] enabled;
    logic [NUM_PORTS-1:0] ocPrev;
    logic [NUM_PORTS-1:0] ocChange;
    logic [NUM_PORTS-1:0] blink;
    logic [NUM_PORTS-1:0] irqStat;
    logic [NUM_PORTS-1:0] irqMask;
    logic [CNT_W-1:0]     blinkCnt;
    logic                 blinkPhase;
    logic [NUM_PORTS-1:0] ledN;
    logic [DATA_W-1:0]    rdata;
    logic                 irq;
  } hpm_state_t;

  localparam hpm_state_t ST_RESET = '{cfgStat: CSR_RESET, ledN: '1, default: '0};

endpackage : hpm_pkg

/* core/hpm_sync.sv */
`timescale 1ns/1ps
module hpm_sync #(
  parameter int               WIDTH     = 4,
  parameter logic [WIDTH-1:0] RESET_VAL = '1
) (
  // Clock and reset
  input  wire logic             clk,
  input  wire logic             rst_b,
  // Data
  input  wire logic [WIDTH-1:0] din,
  output logic      [WIDTH-1:0] dout
);

  // Stage 0 is read only by stage 1.
  logic [1:0][WIDTH-1:0] syncStage_ff;

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      syncStage_ff <= {RESET_VAL, RESET_VAL};
    end else begin
      syncStage_ff <= {syncStage_ff[0], din};
    end
  end

  assign dout = syncStage_ff[1];

endmodule : hpm_sync

/* tb/hpm_port_model.sv */
`timescale 1ns/1ps
module hpm_port_model
  import hpm_pkg::*;
(
  // Fault orders from the bench
  input  wire logic [NUM_PORTS-1:0] faultReq,
  // Port pins
  input  wire logic [NUM_PORTS-1:0] portStatusIndicator_n,
  output logic      [NUM_PORTS-1:0] portOvercurrentSense_n,
  output logic      [NUM_PORTS-1:0] ledLit
);
  // --------------------------------------------------------------
  // Detector and lamp
  // --------------------------------------------------------------
  // Each detector pulls its own flag low for as long as its fault lasts.
  assign portOvercurrentSense_n = ~faultReq;
  assign ledLit                 = ~portStatusIndicator_n;
endmodule : hpm_port_model

/* tb/hpm_port_power_tb.sv */
`timescale 1ns/1ps
module hpm_port_power_tb
  import hpm_pkg::*;
;
  // --------------------------------------------------------------
  // Signals
  // --------------------------------------------------------------
  localparam int HALF = 8;
  logic                 clk      = 1'b0;
  logic                 rst_b    = 1'b0;
  logic [ADDR_W-1:0]    addr     = '0;
  logic [DATA_W-1:0]    wdata    = '0;
  logic                 wrStb    = 1'b0;
  logic                 rdStb    = 1'b0;
  logic [NUM_PORTS-1:0] faultReq = '0;
  logic [DATA_W-1:0]    rdata;
  logic                 irq;
  logic [NUM_PORTS-1:0] sense_n;
  logic [NUM_PORTS-1:0] power;
  logic [NUM_PORTS-1:0] led_n;
  logic [NUM_PORTS-1:0] ledLit;
  int                   n_mismatch = 0;
  int                   n_compared = 0;

  always #20 clk = ~clk;

  hpm_port_power #(.HALF_PERIOD_CYC(HALF)) hpm_port_power_i (.clk(clk), .rst_b(rst_b), .addr(addr),
    .wdata(wdata), .wrStb(wrStb), .rdStb(rdStb), .rdata(rdata), .irq(irq),
    .portOvercurrentSense_n(sense_n), .portPowerEnable(power), .portStatusIndicator_n(led_n));
  hpm_port_model hpm_port_model_i (.faultReq(faultReq), .portStatusIndicator_n(led_n),
    .portOvercurrentSense_n(sense_n), .ledLit(ledLit));

  // --------------------------------------------------------------
  // Shared tasks
  // --------------------------------------------------------------
  task automatic results();
    $display("compared %0d mismatched %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : results

  task automatic chk(input string what, input logic [DATA_W-1:0] exp, input logic [DATA_W-1:0] got);
    n_compared++;
    if (got !== exp) begin
      n_mismatch++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    @(posedge clk);
    addr  <= a;
    wdata <= d;
    wrStb <= 1'b1;
    @(posedge clk);
    wrStb <= 1'b0;
    #1;
  endtask : wr

  task automatic rdChk(input string what, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] exp);
    @(posedge clk);
    addr  <= a;
    rdStb <= 1'b1;
    @(posedge clk);
    rdStb <= 1'b0;
    #1;
    chk(what, exp, rdata);
  endtask : rdChk

  task automatic fault(input logic [NUM_PORTS-1:0] f);
    @(posedge clk);
    faultReq <= f;
    repeat (4) @(posedge clk);
    #1;
  endtask : fault

  // Measures the cycles between two successive changes of one lamp.
  task automatic blinkChk(input int p);
    int   t;
    logic v;
    for (int k = 0; k < 2; k++) begin
      v = led_n[p];
      t = 0;
      while (led_n[p] === v && t < 40) begin
        @(posedge clk);
        #1;
        t++;
      end
      if (t == 40) begin
        n_mismatch++;
        results();
      end
    end
    chk("blink half period", HALF, t);
  endtask : blinkChk

  // --------------------------------------------------------------
  // Scenarios
  // --------------------------------------------------------------
  task automatic tReset();
    chk("power", 4'h0, power);
    chk("lamps", 4'hf, led_n);
    chk("irq", 1'b0, irq);
    rdChk("CTRL", REG_CTRL, 32'h0);
    $display("test reset done");
  endtask : tReset

  task automatic tPower();
    wr(REG_CMD, 32'h1);
    chk("power unconfigured", 4'h0, power);
    wr(REG_CTRL, 32'h1);
    wr(REG_CMD, 32'h1);
    chk("power set", 4'h1, power);
    wr(REG_CMD, 32'h500);
    chk("lamp enabled", 4'he, led_n);
    wr(REG_CMD, 32'h1000);
    chk("lamp disabled", 4'hf, led_n);
    rdChk("unmapped", 8'h1c, 32'h0);
    wr(REG_CMD, 32'h6);
    chk("power three", 4'h7, power);
    $display("test power done");
  endtask : tPower

  task automatic tOvercurrent();
    wr(REG_IRQ_MASK, 32'h2);
    fault(4'h2);
    chk("power after fault", 4'h5, power);
    chk("irq", 1'b1, irq);
    rdChk("PSTAT", REG_PSTAT, 32'h2025);
    rdChk("CHG", REG_CHG, 32'h2);
    rdChk("IRQ_STAT", REG_IRQ_STAT, 32'h2);
    rdChk("IRQ_MASK", REG_IRQ_MASK, 32'h2);
    blinkChk(1);
    fault(4'h0);
    wr(REG_CHG, 32'h2);
    wr(REG_IRQ_STAT, 32'h2);
    rdChk("CHG cleared", REG_CHG, 32'h0);
    chk("irq cleared", 1'b0, irq);
    blinkChk(1);
    wr(REG_CMD, 32'h20);
    repeat (HALF + 1) @(posedge clk);
    #1;
    chk("lamps after clear", 4'hf, led_n);
    chk("power after clear", 4'h5, power);
    wr(REG_CMD, 32'h400);
    chk("lamp port two", 4'hb, led_n);
    wr(REG_CTRL, 32'h0);
    chk("power deconfigured", 4'h0, power);
    chk("lamps deconfigured", 4'hf, ledLit ^ 4'hf);
    $display("test overcurrent done");
  endtask : tOvercurrent

  task automatic tSelfPowered();
    wr(REG_MODE, 32'h1);
    wr(REG_CTRL, 32'h1);
    wr(REG_CMD, 32'h9);
    fault(4'h8);
    chk("power self", 4'h1, power);
    chk("irq masked", 1'b0, irq);
    wr(REG_CMD, 32'h8);
    chk("power refused in fault", 4'h1, power);
    rdChk("MODE", REG_MODE, 32'h1);
    rdChk("CHG self", REG_CHG, 32'h8);
    blinkChk(3);
    fault(4'h0);
    @(posedge clk);
    rst_b <= 1'b0;
    repeat (2) @(posedge clk);
    rst_b <= 1'b1;
    #1;
    chk("power reset", 4'h0, power);
    chk("lamps reset", 4'hf, led_n);
    rdChk("CTRL reset", REG_CTRL, 32'h0);
    rdChk("MODE reset", REG_MODE, 32'h0);
    $display("test self powered done");
  endtask : tSelfPowered

  initial begin
    repeat (8) @(posedge clk);
    rst_b <= 1'b1;
    @(posedge clk);
    #1;
    tReset();
    tPower();
    tOvercurrent();
    tSelfPowered();
    results();
  end
endmodule : hpm_port_power_tb
